// ===== rtl/sbi_arbiter.sv
/*
 * sbi_arbiter: strict-priority arbiter with token classes.
 * Assumes a registered one-hot owner.
 */
`timescale 1ns/100ps
module sbi_arbiter import sbi_pkg::*; (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [2:0]  req,
  input  wire logic [2:0]  owner,
  input  wire logic        token_scheme_enable,
  input  wire logic [15:0] token_refresh_period,
  input  wire logic [3:0]  level [3],
  input  wire logic [15:0] weight [3],
  output logic      [2:0]  winner
);

  logic [15:0] tokens [3];
  logic [15:0] next_tokens [3];
  logic [15:0] period_cnt;
  logic [15:0] next_period_cnt;
  logic [5:0]  best;
  logic [5:0]  k;

  // token class, then level, then cpu
  function automatic logic [5:0] prio_key(input logic has_tok, input logic [3:0] lvl, input int idx);
    prio_key = {has_tok, lvl, (idx == 0)};
  endfunction

  always_comb begin
    winner = '0;
    best   = '0;
    k      = '0;
    for (int i = 0; i < 3; i++) begin
      // R16
      k = prio_key(!token_scheme_enable || weight[i] == '0 || tokens[i] != '0, level[i], i); // R14 R15
      if (req[i] && (winner == '0 || k > best)) begin // R11 R12
        winner = 3'(1 << i);
        best   = k;
      end
    end
  end

  always_comb begin
    next_period_cnt = period_cnt + 16'h0001;
    next_tokens     = tokens;
    if (period_cnt >= token_refresh_period - 16'h0001) begin
      next_period_cnt = '0;
      next_tokens     = weight; // R13
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (owner[i] && tokens[i] != '0) begin
          next_tokens[i] = tokens[i] - 16'h0001; // R14
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin // R24
    if (!rst_b) begin
      period_cnt <= '0;
      tokens     <= '{default: 16'h0000};
    end else begin
      period_cnt <= next_period_cnt;
      tokens     <= next_tokens;
    end
  end

endmodule // sbi_arbiter

// ===== rtl/sbi_decode.sv
/*
 * sbi_decode: boot/normal, small/large map address decoder.
 * Assumes a byte address; combinational.
 */
`timescale 1ns/100ps
module sbi_decode import sbi_pkg::*; (
  input  wire logic [31:0] addr,
  input  wire logic        boot_map,
  input  wire logic        large_map,
  output sbi_region_t      region,
  output logic      [31:0] offset
);

  always_comb begin
    region = RG_RSVD;
    unique case (addr[31:28])
      4'h0: region = boot_map ? RG_FLASH : RG_DDR;                  // R3 R4 R7 R8
      4'h1: region = boot_map ? RG_RSVD : RG_DDR;                   // R7 R8
      4'h2, 4'h3: region = (!large_map || !boot_map) ? RG_DDR : RG_RSVD; // R6 R8
      4'h4: region = RG_FLASH;
      4'h5, 4'h6: region = RG_RSVD;
      4'h7: begin
        // R20
        if (addr[27:24] == REG_LOCAL) begin
          region = RG_REGL;
        end else if (addr[27:24] == REG_CORE) begin
          region = RG_REGC;
        end
      end
      4'h8, 4'h9, 4'ha, 4'hb: region = large_map ? RG_DDR : RG_RSVD; // R6 R8
      default: region = RG_PCIE;
    endcase
    // mirror and fixed window share offsets
    unique case (region)
      RG_FLASH: offset = addr & MASK_256M;
      RG_DDR:   offset = addr & (large_map ? MASK_1G : MASK_512M);
      RG_PCIE:  offset = addr & MASK_1G;
      default:  offset = addr & MASK_256M;
    endcase
  end

endmodule // sbi_decode

// ===== rtl/sbi_interconnect.sv
/*
 * sbi_interconnect: shared system bus between three masters and the memory-mapped slaves,
 * with its configuration reached over an AHB-Lite slave port.
 * Assumes masters hold a request until m_done and slaves hold s_rdata with s_ready.
 */
// Added by the designer: the AHB-Lite register port and the register addresses.
// Functional notes
// [R1] 32-bit address and data, three masters only
// [R2] byte addresses; 8/16/32 singles, word bursts
// [R3] reset selects boot map, flash mirrored low
// [R4] normal map mirrors ddr at bottom
// [R5] new mapping applied when select bit read
// [R6] 512 MB default, large map by bit
// [R7] 512 MB map region layout
// [R8] 1 GB map region layout
// [R9] cpu-only soft reset keeps mapping
// [R10] frame dma has own paths elsewhere
// [R11] strict priority, cpu highest, level 15 top
// [R12] unused guaranteed bandwidth goes to requesters
// [R13] refresh period reloads token weights
// [R14] owner spends one token per cycle
// [R15] token holders beat others, levels within class
// [R16] zero weight means unlimited tokens
// [R17] register region: word accesses only; not enforced, reads forward m_size, buffered writes always go out as words
// [R18] one-word write buffer, stalls when busy
// [R19] read after write waits for buffer
// [R20] local and switch-core register windows
// [R21] flash reads forwarded, writes dropped
// [R22] ddr and pcie forwarded to controllers
// [R23] reserved space reads zero, ignores writes
// [R24] one subsystem clock for the interconnect
`timescale 1ns/100ps
module sbi_interconnect import sbi_pkg::*; (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        soft_reset_req,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  input  wire logic [2:0]  m_req,
  input  wire logic [31:0] m_addr [3],
  input  wire logic [2:0]  m_write,
  input  wire logic [1:0]  m_size [3],
  input  wire logic [31:0] m_wdata [3],
  input  wire logic [2:0]  m_last,
  output logic      [2:0]  m_gnt,
  output logic      [2:0]  m_done,
  output logic      [31:0] m_rdata,
  output logic             s_valid,
  output logic      [2:0]  s_region,
  output logic      [31:0] s_addr,
  output logic             s_write,
  output logic      [1:0]  s_size,
  output logic      [31:0] s_wdata,
  input  wire logic        s_ready,
  input  wire logic [31:0] s_rdata
);

  // ****************************************
  // configuration state
  // ****************************************
  logic        boot_map_select;
  logic        boot_map;
  logic        large_memory_map_enable;
  logic        token_scheme_enable;
  logic        cpu_only_reset;
  logic [3:0]  prio_level [3];
  logic [15:0] token_weight [3];
  logic [15:0] token_refresh_period;
  logic        a_valid;
  logic        a_write;
  logic [7:0]  a_addr;
  logic        rd_pend;
  logic        next_boot_map_select;
  logic        next_boot_map;
  logic        next_large;
  logic        next_token_en;
  logic        next_cpu_only;
  logic [3:0]  next_prio_level [3];
  logic [15:0] next_token_weight [3];
  logic [15:0] next_refresh;
  logic        next_a_valid;
  logic        next_a_write;
  logic [7:0]  next_a_addr;
  logic        next_rd_pend;
  logic        next_hreadyout;
  logic [31:0] next_hrdata;

  // ****************************************
  // bus state
  // ****************************************
  sbi_state_t  state;
  sbi_state_t  next_state;
  logic [2:0]  owner;
  logic [2:0]  next_owner;
  logic [2:0]  winner;
  logic [2:0]  next_m_done;
  logic [31:0] next_m_rdata;
  logic        s_drain;
  logic        next_s_drain;
  logic        next_s_valid;
  logic [2:0]  next_s_region;
  logic [31:0] next_s_addr;
  logic        next_s_write;
  logic [1:0]  next_s_size;
  logic [31:0] next_s_wdata;
  logic        wb_full;
  logic        next_wb_full;
  logic [31:0] wb_addr;
  logic [31:0] next_wb_addr;
  logic [31:0] wb_data;
  logic [31:0] next_wb_data;
  sbi_region_t region;
  logic [31:0] offset;
  logic [1:0]  idx;
  logic        cur_write;
  logic        cur_last;
  logic        is_reg;

  function automatic logic [1:0] onehot_index(input logic [2:0] oh);
    onehot_index = oh[2] ? 2'd2 : (oh[1] ? 2'd1 : 2'd0);
  endfunction

  // ****************************************
  // register port, one wait state on reads
  // ****************************************
  always_comb begin
    next_boot_map_select = boot_map_select;
    next_boot_map        = boot_map;
    next_large           = large_memory_map_enable;
    next_token_en        = token_scheme_enable;
    next_cpu_only        = cpu_only_reset;
    next_prio_level      = prio_level;
    next_token_weight    = token_weight;
    next_refresh         = token_refresh_period;
    next_hrdata          = hrdata;
    next_hreadyout       = 1'b1;
    next_rd_pend         = 1'b0;
    if (a_valid && a_write) begin
      unique case (a_addr)
        OFS_CTRL: begin
          next_boot_map_select = hwdata[CTRL_BOOT];
          next_large           = hwdata[CTRL_LARGE]; // R6
          next_token_en        = hwdata[CTRL_TOKEN];
          next_cpu_only        = hwdata[CTRL_CPUONLY];
        end
        OFS_PL_BASE:         next_prio_level[M_CPU]    = hwdata[3:0];
        OFS_PL_BASE + 8'h04: next_prio_level[M_PCIE]   = hwdata[3:0];
        OFS_PL_BASE + 8'h08: next_prio_level[M_ACC]    = hwdata[3:0];
        OFS_REFRESH:         next_refresh              = hwdata[15:0];
        OFS_WT_BASE:         next_token_weight[M_CPU]  = hwdata[15:0];
        OFS_WT_BASE + 8'h04: next_token_weight[M_PCIE] = hwdata[15:0];
        OFS_WT_BASE + 8'h08: next_token_weight[M_ACC]  = hwdata[15:0];
        default: ;
      endcase
    end
    if (rd_pend) begin
      unique case (a_addr)
        OFS_CTRL: begin
          next_hrdata   = {28'h0000000, cpu_only_reset, token_scheme_enable,
                           large_memory_map_enable, boot_map_select};
          next_boot_map = boot_map_select; // R5
        end
        OFS_STATUS:          next_hrdata = {24'h000000, state, owner, wb_full, boot_map};
        OFS_PL_BASE:         next_hrdata = {28'h0000000, prio_level[M_CPU]};
        OFS_PL_BASE + 8'h04: next_hrdata = {28'h0000000, prio_level[M_PCIE]};
        OFS_PL_BASE + 8'h08: next_hrdata = {28'h0000000, prio_level[M_ACC]};
        OFS_REFRESH:         next_hrdata = {16'h0000, token_refresh_period};
        OFS_WT_BASE:         next_hrdata = {16'h0000, token_weight[M_CPU]};
        OFS_WT_BASE + 8'h04: next_hrdata = {16'h0000, token_weight[M_PCIE]};
        OFS_WT_BASE + 8'h08: next_hrdata = {16'h0000, token_weight[M_ACC]};
        default:             next_hrdata = 32'h00000000;
      endcase
    end
    next_a_valid = hsel && htrans[1] && hready;
    next_a_write = hwrite;
    next_a_addr  = haddr[7:0];
    if (next_a_valid && !hwrite) begin
      next_rd_pend   = 1'b1;
      next_hreadyout = 1'b0;
    end
    // cpu-only soft reset keeps the mapping
    if (soft_reset_req && !cpu_only_reset) begin
      next_boot_map_select = 1'b1; // R9
      next_boot_map        = 1'b1; // R3
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      boot_map_select         <= 1'b1;
      boot_map                <= 1'b1; // R3
      large_memory_map_enable <= 1'b0; // R6
      token_scheme_enable     <= 1'b0;
      cpu_only_reset          <= 1'b0;
      prio_level              <= '{CPU_PRIORITY_LEVEL_RST, PCIE_PRIORITY_LEVEL_RST, PL_ACC_RST}; // R11
      token_weight            <= '{default: WT_RST};
      token_refresh_period    <= REFRESH_RST;
      a_valid                 <= 1'b0;
      a_write                 <= 1'b0;
      a_addr                  <= 8'h00;
      rd_pend                 <= 1'b0;
      hreadyout               <= 1'b1;
      hrdata                  <= 32'h00000000;
      hresp                   <= 1'b0;
    end else begin
      boot_map_select         <= next_boot_map_select;
      boot_map                <= next_boot_map;
      large_memory_map_enable <= next_large;
      token_scheme_enable     <= next_token_en;
      cpu_only_reset          <= next_cpu_only;
      prio_level              <= next_prio_level;
      token_weight            <= next_token_weight;
      token_refresh_period    <= next_refresh;
      a_valid                 <= next_a_valid;
      a_write                 <= next_a_write;
      a_addr                  <= next_a_addr;
      rd_pend                 <= next_rd_pend;
      hreadyout               <= next_hreadyout;
      hrdata                  <= next_hrdata;
      hresp                   <= 1'b0;
    end
  end

  // ****************************************
  // arbitration and decode
  // ****************************************
  sbi_arbiter u_arbiter (
    .clock                (clock),
    .rst_b                (rst_b),
    .req                  (m_req),
    .owner                (owner),
    .token_scheme_enable  (token_scheme_enable),
    .token_refresh_period (token_refresh_period),
    .level                (prio_level),
    .weight               (token_weight),
    .winner               (winner)
  );

  assign idx       = onehot_index(owner);
  assign cur_write = m_write[idx];
  assign cur_last  = m_last[idx];

  sbi_decode u_decode (
    .addr      (m_addr[idx]),
    .boot_map  (boot_map),
    .large_map (large_memory_map_enable),
    .region    (region),
    .offset    (offset)
  );

  assign is_reg = (region == RG_REGL) || (region == RG_REGC);

  // ****************************************
  // transfer sequencing
  // ****************************************
  // frame dma has its own paths; R10
  always_comb begin
    next_state    = state;
    next_owner    = owner;
    next_m_done   = 3'b000;
    next_m_rdata  = m_rdata;
    next_s_valid  = s_valid;
    next_s_region = s_region;
    next_s_addr   = s_addr;
    next_s_write  = s_write;
    next_s_size   = s_size;
    next_s_wdata  = s_wdata;
    next_s_drain  = s_drain;
    next_wb_full  = wb_full;
    next_wb_addr  = wb_addr;
    next_wb_data  = wb_data;
    if (s_valid && s_drain && s_ready) begin
      next_s_valid = 1'b0;
      next_s_drain = 1'b0;
      next_wb_full = 1'b0; // R18
    end
    unique case (state)
      ST_IDLE: begin
        if (owner == 3'b000) begin
          next_owner = winner; // R1 R11
        end else if (!m_req[idx]) begin
          next_owner = 3'b000;
        end else if (region == RG_RSVD || (region == RG_FLASH && cur_write)) begin
          // finish at once, never hang
          next_m_done  = owner; // R21 R23
          next_m_rdata = 32'h00000000;
          next_state   = ST_DONE;
          if (cur_last) begin
            next_owner = 3'b000;
          end
        end else if (is_reg && cur_write) begin
          if (!wb_full) begin
            next_wb_full = 1'b1; // R18
            next_wb_addr = {region == RG_REGC, 3'b000, offset[27:0]};
            next_wb_data = m_wdata[idx];
            next_m_done  = owner;
            next_state   = ST_DONE;
            if (cur_last) begin
              next_owner = 3'b000;
            end
          end
        end else if (!s_valid && !wb_full) begin
          // buffered write drains first; R19
          next_s_valid  = 1'b1; // R22
          next_s_region = region; // R20
          next_s_addr   = offset;
          next_s_write  = cur_write;
          next_s_size   = m_size[idx]; // R2
          next_s_wdata  = m_wdata[idx];
          next_state    = ST_WAIT;
        end
        if (wb_full && !s_valid) begin
          next_s_valid  = 1'b1;
          next_s_drain  = 1'b1;
          next_s_region = wb_addr[31] ? RG_REGC : RG_REGL;
          next_s_addr   = {4'h0, wb_addr[27:0]};
          next_s_write  = 1'b1;
          next_s_size   = 2'h2;
          next_s_wdata  = wb_data;
        end
      end
      ST_WAIT: begin
        if (s_ready) begin
          next_s_valid = 1'b0; // R18
          next_m_done  = owner;
          next_m_rdata = s_write ? 32'h00000000 : s_rdata;
          next_state   = ST_DONE;
          if (cur_last) begin
            next_owner = 3'b000;
          end
        end
      end
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state    <= ST_IDLE;
      owner    <= 3'b000;
      m_done   <= 3'b000;
      m_rdata  <= 32'h00000000;
      s_valid  <= 1'b0;
      s_region <= 3'h0;
      s_addr   <= 32'h00000000;
      s_write  <= 1'b0;
      s_size   <= 2'h0;
      s_wdata  <= 32'h00000000;
      s_drain  <= 1'b0;
      wb_full  <= 1'b0;
      wb_addr  <= 32'h00000000;
      wb_data  <= 32'h00000000;
    end else begin
      state    <= next_state;
      owner    <= next_owner;
      m_done   <= next_m_done;
      m_rdata  <= next_m_rdata;
      s_valid  <= next_s_valid;
      s_region <= next_s_region;
      s_addr   <= next_s_addr;
      s_write  <= next_s_write;
      s_size   <= next_s_size;
      s_wdata  <= next_s_wdata;
      s_drain  <= next_s_drain;
      wb_full  <= next_wb_full;
      wb_addr  <= next_wb_addr;
      wb_data  <= next_wb_data;
    end
  end

  assign m_gnt = owner;

endmodule // sbi_interconnect

// ===== rtl/sbi_pkg.sv
/*
 * sbi_pkg: constants and types of the interconnect.
 * Assumes one clock domain.
 */
package sbi_pkg;

  // ****************************************
  // clocking and masters
  // ****************************************
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned NUM_MASTERS  = 3;
  localparam int unsigned M_CPU        = 0;
  localparam int unsigned M_PCIE       = 1;
  localparam int unsigned M_ACC        = 2;

  // ****************************************
  // configuration registers (byte offsets)
  // ****************************************
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_PL_BASE   = 8'h08;
  localparam logic [7:0] OFS_REFRESH   = 8'h14;
  localparam logic [7:0] OFS_WT_BASE   = 8'h18;
  localparam int unsigned CTRL_BOOT    = 0;
  localparam int unsigned CTRL_LARGE   = 1;
  localparam int unsigned CTRL_TOKEN   = 2;
  localparam int unsigned CTRL_CPUONLY = 3;
  localparam logic [3:0]  CPU_PRIORITY_LEVEL_RST   = 4'h2;
  localparam logic [3:0]  PCIE_PRIORITY_LEVEL_RST  = 4'h1;
  localparam logic [3:0]  PL_ACC_RST   = 4'h0;
  localparam logic [15:0] WT_RST       = 16'h0000;
  localparam logic [15:0] REFRESH_RST  = 16'h0800;

  // ****************************************
  // address map
  // ****************************************
  localparam logic [31:0] MASK_256M    = 32'h0fffffff;
  localparam logic [31:0] MASK_512M    = 32'h1fffffff;
  localparam logic [31:0] MASK_1G      = 32'h3fffffff;
  localparam logic [3:0]  REG_LOCAL    = 4'h0;
  localparam logic [3:0]  REG_CORE     = 4'h1;

  typedef enum logic [2:0] {
    RG_RSVD  = 3'h0,
    RG_DDR   = 3'h1,
    RG_FLASH = 3'h2,
    RG_REGL  = 3'h3,
    RG_REGC  = 3'h4,
    RG_PCIE  = 3'h5
  } sbi_region_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } sbi_state_t;

endpackage

// ===== sim/sbi_interconnect_tb.sv
/* sbi_interconnect_tb: self-checking bench of the interconnect.
   Assumes one slave model on the forward port; the cpu port is the main master. */
`timescale 1ns/100ps
module sbi_interconnect_tb import sbi_pkg::*; ;
  logic        clock = 0, rst_b = 0, soft_reset_req = 0, hsel = 0, hwrite = 0, slow = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, m_rdata, s_addr, s_wdata, s_rdata, d, of, hd;
  logic [1:0]  htrans = '0, s_size;
  logic [2:0]  hsize = 3'h2, m_req = '0, m_write = '0, m_last = '0, m_gnt, m_done, s_region, rg;
  logic        hreadyout, hresp, s_valid, s_write, s_ready, fw;
  logic [31:0] m_addr [3], m_wdata [3];
  logic [1:0]  m_size [3];
  int          num_errors = 0, tests_run = 0;
  always #5 clock = ~clock;
  sbi_interconnect i_sbi_interconnect (.hready(hreadyout), .*);
  sbi_slave_model i_sbi_slave_model (.*);
  // ****
  // common tasks
  // ****
  task stop_test;
    $display("mismatches %0d comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task hang;
    num_errors++;
    $display("unexpected wait expected answer seen timeout");
    stop_test;
  endtask
  task wait_ready;
    for (int n = 0; n < 50; n++) begin
      @(negedge clock);
      hd = hrdata;
      if (hreadyout === 1'b1) begin
        @(posedge clock);
        return;
      end
    end
    hang;
  endtask
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    wait_ready;
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_ready;
    rd = hd;
  endtask
  // fw: direction of first slave request
  task macc(input int i, input logic [31:0] a, input logic wr, output logic [31:0] rd,
            output logic [2:0] rg, output logic [31:0] of, output logic fw);
    bit seen;
    seen = 0;
    rg = 3'h0;
    of = '0;
    fw = 1'b0;
    @(posedge clock);
    m_addr[i]  <= a;
    m_write[i] <= wr;
    m_wdata[i] <= a ^ 32'h0f0f0f0f;
    m_last[i]  <= 1'b1;
    m_req[i]   <= 1'b1;
    for (int n = 0; n < 200; n++) begin
      @(negedge clock);
      if (s_valid === 1'b1 && !seen) begin
        seen = 1;
        fw = s_write;
      end
      if (s_valid === 1'b1 && s_ready === 1'b1) begin
        rg = s_region;
        of = s_addr;
      end
      if (m_done[i] === 1'b1) begin
        rd = m_rdata;
        @(posedge clock);
        m_req[i] <= 1'b0;
        return;
      end
    end
    hang;
  endtask
  // ****
  // scenarios
  // ****
  task t_reset;
    ahb(0, OFS_CTRL, 0, d);
    chk("ctrl", 32'h1, d);
    ahb(0, OFS_PL_BASE, 0, d);
    chk("cpu level", 32'h2, d);
    ahb(0, 8'h40, 0, d);
    chk("unmapped", 32'h0, d);
    $display("reset values done");
  endtask
  task map_case(input logic [31:0] c, input logic rdb, wr, input logic [31:0] a,
                input logic [2:0] r, input logic [31:0] o);
    ahb(1, OFS_CTRL, c, d);
    if (rdb) ahb(0, OFS_CTRL, 0, d);
    macc(0, a, wr, d, rg, of, fw);
    chk("region", {29'h0, r}, {29'h0, rg});
    chk("offset", o, of);
    if (!wr) chk("read data", (r == RG_RSVD) ? 32'h0 : o ^ 32'ha5a50000, d);
  endtask
  task t_map;
    map_case(32'h1, 1, 0, 32'h00000010, RG_FLASH, 32'h10);
    map_case(32'h1, 1, 0, 32'h10000004, RG_RSVD, 32'h0);
    map_case(32'h0, 0, 0, 32'h00000010, RG_FLASH, 32'h10);
    map_case(32'h0, 1, 0, 32'h10000020, RG_DDR, 32'h10000020);
    map_case(32'h0, 1, 0, 32'h20000040, RG_DDR, 32'h40);
    map_case(32'h0, 1, 0, 32'h40000100, RG_FLASH, 32'h100);
    map_case(32'h0, 1, 1, 32'h40000004, RG_RSVD, 32'h0);
    map_case(32'h0, 1, 0, 32'h70000008, RG_REGL, 32'h8);
    map_case(32'h0, 1, 0, 32'h71000008, RG_REGC, 32'h01000008);
    map_case(32'h0, 1, 0, 32'hc0000100, RG_PCIE, 32'h100);
    map_case(32'h0, 1, 0, 32'h80000000, RG_RSVD, 32'h0);
    map_case(32'h2, 1, 0, 32'h30000000, RG_DDR, 32'h30000000);
    map_case(32'h2, 1, 0, 32'h80000010, RG_DDR, 32'h10);
    map_case(32'h3, 1, 0, 32'h20000000, RG_RSVD, 32'h0);
    map_case(32'h3, 1, 0, 32'h00000040, RG_FLASH, 32'h40);
    $display("address map done");
  endtask
  task t_regs;
    slow <= 1'b1;
    macc(0, 32'h70000010, 1, d, rg, of, fw);
    chk("buffered write region", 32'h0, {29'h0, rg});
    macc(0, 32'h70000014, 0, d, rg, of, fw);
    chk("drain first", 32'h1, {31'h0, fw});
    chk("read offset", 32'h14, of);
    chk("read data", 32'h14 ^ 32'ha5a50000, d);
    slow <= 1'b0;
    $display("register buffer done");
  endtask
  // first grant of two masters
  task race(input logic [2:0] exp);
    logic [2:0] first, dn;
    first = 3'h0;
    @(posedge clock);
    m_addr[0] <= 32'h50000000;
    m_addr[1] <= 32'h50000004;
    m_write   <= 3'h0;
    m_last    <= 3'h7;
    m_req     <= 3'h3;
    for (int n = 0; n < 100; n++) begin
      @(negedge clock);
      if (first === 3'h0) first = m_gnt;
      dn = m_done;
      if (m_req == 3'h0) begin
        chk("first grant", {29'h0, exp}, {29'h0, first});
        return;
      end
      @(posedge clock);
      m_req <= m_req & ~dn;
    end
    hang;
  endtask
  task t_prio;
    race(3'h1);
    ahb(1, OFS_PL_BASE + 8'h04, 32'hf, d);
    race(3'h2);
    $display("priority done");
  endtask
  task pulse;
    @(posedge clock);
    soft_reset_req <= 1'b1;
    repeat (2) @(posedge clock);
    soft_reset_req <= 1'b0;
  endtask
  task t_soft;
    ahb(1, OFS_CTRL, 32'h8, d);
    ahb(0, OFS_CTRL, 0, d);
    pulse;
    ahb(0, OFS_STATUS, 0, d);
    chk("map kept", 32'h0, {31'h0, d[0]});
    ahb(1, OFS_CTRL, 32'h0, d);
    ahb(0, OFS_CTRL, 0, d);
    pulse;
    ahb(0, OFS_STATUS, 0, d);
    chk("map reset", 32'h1, {31'h0, d[0]});
    $display("soft reset done");
  endtask
  initial begin
    m_addr  = '{default: '0};
    m_wdata = '{default: '0};
    m_size  = '{default: 2'h2};
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    t_reset;
    t_map;
    t_regs;
    t_prio;
    t_soft;
    stop_test;
  end
endmodule // sbi_interconnect_tb

// ===== sim/sbi_monitor.sv
/* sbi_monitor: port assertions of the shared bus interconnect.
   Assumes one clock domain and the async active-low reset. */
`timescale 1ns/100ps
module sbi_monitor import sbi_pkg::*; (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [2:0]  m_req,
  input wire logic [2:0]  m_gnt,
  input wire logic [2:0]  m_done,
  input wire logic        s_valid,
  input wire logic [2:0]  s_region,
  input wire logic [31:0] s_addr,
  input wire logic        s_write,
  input wire logic        s_ready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // ****
  // bus and master side
  // ****
  AST_HRESP_OKAY: assert property (hresp == 1'b0) else $error("hresp not okay");
  AST_READ_WAIT: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_WRITE_NOWAIT: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write stalled");
  AST_GNT_ONEHOT: assert property ($onehot0(m_gnt)) else $error("two owners");
  AST_GNT_REQ: assert property ((m_gnt & ~$past(m_gnt)) != 3'h0 |->
    (m_gnt & ~$past(m_gnt) & ~$past(m_req)) == 3'h0) else $error("grant without request");
  AST_DONE_OWNER: assert property (m_done != 3'h0 |-> (m_done & ~$past(m_gnt)) == 3'h0)
    else $error("done to non-owner");
  AST_DONE_PULSE: assert property (m_done != 3'h0 |=> m_done == 3'h0) else $error("done too long");
  // ****
  // slave side
  // ****
  AST_SLAVE_HOLD: assert property (s_valid && !s_ready |=>
    s_valid && $stable(s_addr) && $stable(s_region) && $stable(s_write)) else $error("slave request dropped");
  AST_FLASH_RO: assert property (s_valid && s_region == RG_FLASH |-> !s_write) else $error("flash written");
  AST_NO_RSVD: assert property (s_valid |-> s_region != RG_RSVD) else $error("reserved forwarded");
endmodule // sbi_monitor

bind sbi_interconnect sbi_monitor i_sbi_monitor (.*);

// ===== sim/sbi_slave_model.sv
/* sbi_slave_model: forwarded-slave partner, prompt or slow.
   Assumes s_valid is held until s_ready is seen. */
`timescale 1ns/100ps
module sbi_slave_model (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        s_valid,
  input  wire logic        slow,
  input  wire logic [31:0] s_addr,
  output logic             s_ready,
  output logic      [31:0] s_rdata
);
  logic [3:0]  cnt;
  logic [31:0] val;
  assign val = s_addr ^ 32'ha5a50000;
  // inverted outside the answer cycle
  assign s_rdata = s_ready ? val : ~val;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt     <= 4'h0;
      s_ready <= 1'b0;
    end else if (s_valid && !s_ready && cnt >= (slow ? 4'h8 : 4'h0)) begin
      s_ready <= 1'b1;
      cnt     <= 4'h0;
    end else begin
      s_ready <= 1'b0;
      cnt     <= s_valid ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule // sbi_slave_model
